// ### core/ldev_cfg_consts.vh
// constants for the logical device configuration bank
`ifndef LDEV_CFG_CONSTS_VH
`define LDEV_CFG_CONSTS_VH

// logical device numbers
`define LDN_SERIAL2 8'h02
`define LDN_PARPORT 8'h03
`define LDN_FAN 8'h04

// register indexes, byte address is four times the index
`define IDX_LDN 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_BASE0_HIGH 8'h60
`define IDX_BASE0_LOW 8'h61
`define IDX_BASE1_HIGH 8'h62
`define IDX_BASE1_LOW 8'h63
`define IDX_IRQ_SELECT 8'h70
`define IDX_DMA_SELECT 8'h74
`define IDX_CONFIG0 8'hF0
`define IDX_CONFIG1 8'hF1
`define IDX_CONFIG2 8'hF2
`define IDX_CONFIG3 8'hF3

// reset values
`define RST_LDN 8'h00
`define RST_PP_ACTIVATE 8'h00
`define RST_FAN_ACTIVATE 8'h00
`define RST_PP_PRI_HIGH 8'h03
`define RST_FAN_BASE_HIGH 8'h02
`define RST_PP_PRI_LOW 8'h78
`define RST_FAN_BASE_LOW 8'h90
`define RST_PP_SEC_HIGH 8'h07
`define RST_PE_BASE_HIGH 8'h02
`define RST_PP_SEC_LOW 8'h78
`define RST_PE_BASE_LOW 8'h30
`define RST_PP_IRQ 8'h07
`define RST_FAN_IRQ 8'h09
`define RST_PP_DMA 8'h03
`define RST_S2_MODE 8'h00
`define RST_PP_MODE 8'h03
`define RST_PE_ENABLE 8'h00
`define RST_S2_INFRARED 8'h50
`define RST_S2_CARD_CLOCK 8'h00
`define RST_S2_CARD_DIV 8'h7F

// writable bit masks, all other bits read zero except the standby-off flag in bit 7 of the power event register
`define WM_ACTIVATE 8'h01
`define WM_BASE_HIGH 8'h0F
`define WM_PP_BASE_LOW 8'hFC
`define WM_FAN_BASE_LOW 8'hF8
`define WM_IRQ 8'h0F
`define WM_DMA 8'h07
`define WM_S2_MODE 8'h77
`define WM_S2_INFRARED 8'hF8
`define WM_S2_CARD_CLOCK 8'h07
`define WM_S2_CARD_DIV 8'hFF
`define WM_PP_MODE 8'h0F
`define WM_PE_ENABLE 8'h5F

// field positions
`define PE_STANDBY_OFF_BIT 7
`define PE_CARD_WAKE_BIT 6
`define PE_MOUSE_WAKE_BIT 4
`define PP_EPP_LOCK_BIT 2

// serial port 2 mode codes
`define S2_MODE_STANDARD 3'h0
`define S2_MODE_SIR 3'h1
`define S2_MODE_ASK 3'h2
`define S2_MODE_CARD 3'h4

// baud clock source codes
`define BAUD_DIV13 2'h0
`define BAUD_DIV12 2'h1

// infrared turnaround wait length in bit times
`define IR_TURN_WAIT_BITS 8'h28

`endif

// ### core/logical_device_config_bank.v
// configuration register bank for serial port 2, parallel port and fan/power-event device
//
// Behaviour
// (RULE_01) serial 2 mode field bits 6-4 decoded
// (RULE_02) baud clock source from bits 2-1
// (RULE_03) bit 7 clear: wait before transmit
// (RULE_04) bit 6 clear: wait before receive
// (RULE_05) mask bit 5 ignores receive while transmitting
// (RULE_06) half duplex and receive polarity bits
// (RULE_07) card registers act only in card mode; card_clock_divisor_o follows the divisor register in every mode
// (RULE_08) card clock select and divisor field
// (RULE_09) activate bit 0 enables the device
// (RULE_10) base high: bits 7-4 read zero
// (RULE_11) parallel base low bits 1-0 zero
// (RULE_12) fan/event base low bits 2-0 zero
// (RULE_13) primary base bit 2 forces EPP off
// (RULE_14) parallel mode bits enable ECP, EPP
// (RULE_15) POST port disable and interrupt sharing
// (RULE_16) interrupt level in bits 3-0
// (RULE_17) DMA channel in bits 2-0
// (RULE_18) standby off sets bit 7, write-one clears
// (RULE_19) card-detect and mouse wake enables
// (RULE_20) reserved bits read zero, reset defaults
// (RULE_21) selected device number steers accesses
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`include "ldev_cfg_consts.vh"

module logical_device_config_bank (
   input wire clk_i,
   input wire rst_i,
   // wishbone classic slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [9:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // standby supply present, low means it has gone off
   input wire standby_supply_i,
   // serial port 2 settings
   output reg s2_mode_standard_o,
   output reg s2_mode_sir_o,
   output reg amplitude_shift_infrared_o,
   output reg smart_card_mode_o,
   output reg s2_irq_share_o,
   output reg baud_div13_o,
   output reg baud_div12_o,
   output reg tx_turn_wait_o,
   output reg rx_turn_wait_o,
   output reg [7:0] turn_wait_bits_o,
   output reg rx_mask_on_tx_o,
   output reg half_duplex_o,
   output reg sir_rx_active_low_o,
   output reg card_power_switch_active_high_o,
   output reg card_present_active_high_o,
   output reg [1:0] card_clock_select_o,
   output reg [6:0] card_clock_divisor_o,
   // parallel port settings
   output reg parport_enable_o,
   output reg [15:0] parport_primary_base_o,
   output reg [15:0] parport_secondary_base_o,
   output reg [3:0] parport_irq_o,
   output reg [2:0] parport_dma_o,
   output reg parport_ecp_enable_o,
   output reg parport_epp_enable_o,
   output reg parport_irq_share_o,
   output reg post_port_disable_o,
   // fan controller and power events
   output reg fan_enable_o,
   output reg [15:0] fan_base_o,
   output reg [15:0] power_event_base_o,
   output reg [3:0] fan_irq_o,
   output reg standby_off_flag_o,
   output reg card_detect_wake_enable_o,
   output reg mouse_wake_enable_o,
   output reg [3:0] other_wake_enable_o
);

   // register storage, only writable bits and the standby-off flag ever become non-zero
   reg [7:0] logical_device_number;
   reg [7:0] parport_activate;
   reg [7:0] fan_activate;
   reg [7:0] parport_primary_base_high;
   reg [7:0] fan_base_high;
   reg [7:0] parport_primary_base_low;
   reg [7:0] fan_base_low;
   reg [7:0] parport_secondary_base_high;
   reg [7:0] power_event_base_high;
   reg [7:0] parport_secondary_base_low;
   reg [7:0] power_event_base_low;
   reg [7:0] parport_irq_select;
   reg [7:0] fan_irq_select;
   reg [7:0] parport_dma_select;
   reg [7:0] serial2_mode_config;
   reg [7:0] parport_mode_config;
   reg [7:0] power_event_enable_reg;
   reg [7:0] serial2_infrared_config;
   reg [7:0] serial2_card_clock_config;
   reg [7:0] serial2_card_divisor_config;

   // bus decode
   wire [7:0] index; // register index from word address
   wire bus_req; // new request not yet answered
   wire wr_en; // write on lane 0 this cycle
   wire sel_s2; // selected device decodes
   wire sel_pp;
   wire sel_fan;
   wire [7:0] wdata;
   wire [2:0] s2_mode; // serial 2 mode field
   wire s2_card; // card mode active
   wire s2_infrared; // SIR or amplitude-shift infrared
   reg [7:0] rdata; // read mux result
   reg next_standby_flag; // standby-off flag next value

   assign index = adr_i[9:2];
   assign bus_req = cyc_i & stb_i & ~ack_o;
   // byte lane 0 carries the whole 8-bit register
   assign wr_en = bus_req & we_i & sel_i[0];
   assign wdata = dat_i[7:0];
   // (RULE_21) device select compare
   assign sel_s2 = (logical_device_number == `LDN_SERIAL2);
   assign sel_pp = (logical_device_number == `LDN_PARPORT);
   assign sel_fan = (logical_device_number == `LDN_FAN);
   assign s2_mode = serial2_mode_config[6:4];
   assign s2_card = (s2_mode == `S2_MODE_CARD);
   assign s2_infrared = (s2_mode == `S2_MODE_SIR) | (s2_mode == `S2_MODE_ASK);

   // keep unwritable bits at zero so read-back never needs masking
   function [7:0] merge;
      input [7:0] old;
      input [7:0] val;
      input [7:0] mask;
      begin
         merge = (old & ~mask) | (val & mask);
      end
   endfunction

   // hit test for a given index within the selected device
   function hit;
      input [7:0] idx;
      input dev;
      begin
         hit = wr_en & dev & (index == idx);
      end
   endfunction

   // read mux; unmapped or unselected reads return zero
   always @* begin
      rdata = 8'h00;
      if (index == `IDX_LDN) begin
         rdata = logical_device_number;
      end else if (sel_s2) begin
         case (index)
            `IDX_CONFIG0: rdata = serial2_mode_config;
            `IDX_CONFIG1: rdata = serial2_infrared_config;
            `IDX_CONFIG2: rdata = serial2_card_clock_config;
            `IDX_CONFIG3: rdata = serial2_card_divisor_config;
            default: rdata = 8'h00;
         endcase
      end else if (sel_pp) begin
         case (index)
            `IDX_ACTIVATE: rdata = parport_activate;
            `IDX_BASE0_HIGH: rdata = parport_primary_base_high;
            `IDX_BASE0_LOW: rdata = parport_primary_base_low;
            `IDX_BASE1_HIGH: rdata = parport_secondary_base_high;
            `IDX_BASE1_LOW: rdata = parport_secondary_base_low;
            `IDX_IRQ_SELECT: rdata = parport_irq_select;
            `IDX_DMA_SELECT: rdata = parport_dma_select;
            `IDX_CONFIG0: rdata = parport_mode_config;
            default: rdata = 8'h00;
         endcase
      end else if (sel_fan) begin
         case (index)
            `IDX_ACTIVATE: rdata = fan_activate;
            `IDX_BASE0_HIGH: rdata = fan_base_high;
            `IDX_BASE0_LOW: rdata = fan_base_low;
            `IDX_BASE1_HIGH: rdata = power_event_base_high;
            `IDX_BASE1_LOW: rdata = power_event_base_low;
            `IDX_IRQ_SELECT: rdata = fan_irq_select;
            `IDX_CONFIG0: rdata = power_event_enable_reg;
            default: rdata = 8'h00;
         endcase
      end
   end

   // standby-off flag: set has priority over a write-one clear
   always @* begin
      next_standby_flag = power_event_enable_reg[`PE_STANDBY_OFF_BIT];
      // (RULE_18) write one clears; terms spelled out so the sensitivity list sees them all
      if (wr_en & sel_fan & (index == `IDX_CONFIG0) & wdata[`PE_STANDBY_OFF_BIT])
         next_standby_flag = 1'b0;
      // (RULE_18) supply loss sets
      if (~standby_supply_i)
         next_standby_flag = 1'b1;
   end

   // bus answer: one wait state, ack for exactly one cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (bus_req)
            dat_o <= {24'h00_0000, rdata};
      end
   end

   // register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         // (RULE_20) defaults on reset
         logical_device_number <= `RST_LDN;
         parport_activate <= `RST_PP_ACTIVATE;
         fan_activate <= `RST_FAN_ACTIVATE;
         parport_primary_base_high <= `RST_PP_PRI_HIGH;
         fan_base_high <= `RST_FAN_BASE_HIGH;
         parport_primary_base_low <= `RST_PP_PRI_LOW;
         fan_base_low <= `RST_FAN_BASE_LOW;
         parport_secondary_base_high <= `RST_PP_SEC_HIGH;
         power_event_base_high <= `RST_PE_BASE_HIGH;
         parport_secondary_base_low <= `RST_PP_SEC_LOW;
         power_event_base_low <= `RST_PE_BASE_LOW;
         parport_irq_select <= `RST_PP_IRQ;
         fan_irq_select <= `RST_FAN_IRQ;
         parport_dma_select <= `RST_PP_DMA;
         serial2_mode_config <= `RST_S2_MODE;
         parport_mode_config <= `RST_PP_MODE;
         power_event_enable_reg <= `RST_PE_ENABLE;
         serial2_infrared_config <= `RST_S2_INFRARED;
         serial2_card_clock_config <= `RST_S2_CARD_CLOCK;
         serial2_card_divisor_config <= `RST_S2_CARD_DIV;
      end else begin
         // device number register is shared by all devices
         if (wr_en & (index == `IDX_LDN))
            logical_device_number <= wdata;
         // (RULE_01) serial 2 mode and clock source storage, plus infrared and card registers
         if (hit(`IDX_CONFIG0, sel_s2))
            serial2_mode_config <= merge(serial2_mode_config, wdata, `WM_S2_MODE);
         if (hit(`IDX_CONFIG1, sel_s2))
            serial2_infrared_config <= merge(serial2_infrared_config, wdata, `WM_S2_INFRARED);
         if (hit(`IDX_CONFIG2, sel_s2))
            serial2_card_clock_config <= merge(serial2_card_clock_config, wdata, `WM_S2_CARD_CLOCK);
         if (hit(`IDX_CONFIG3, sel_s2))
            serial2_card_divisor_config <= merge(serial2_card_divisor_config, wdata, `WM_S2_CARD_DIV);
         // (RULE_09) activate bit only
         if (hit(`IDX_ACTIVATE, sel_pp))
            parport_activate <= merge(parport_activate, wdata, `WM_ACTIVATE);
         if (hit(`IDX_ACTIVATE, sel_fan))
            fan_activate <= merge(fan_activate, wdata, `WM_ACTIVATE);
         // (RULE_10) high nibble stays zero
         if (hit(`IDX_BASE0_HIGH, sel_pp))
            parport_primary_base_high <= merge(parport_primary_base_high, wdata, `WM_BASE_HIGH);
         if (hit(`IDX_BASE1_HIGH, sel_pp))
            parport_secondary_base_high <= merge(parport_secondary_base_high, wdata, `WM_BASE_HIGH);
         if (hit(`IDX_BASE0_HIGH, sel_fan))
            fan_base_high <= merge(fan_base_high, wdata, `WM_BASE_HIGH);
         if (hit(`IDX_BASE1_HIGH, sel_fan))
            power_event_base_high <= merge(power_event_base_high, wdata, `WM_BASE_HIGH);
         // (RULE_11) parallel low bits fixed
         if (hit(`IDX_BASE0_LOW, sel_pp))
            parport_primary_base_low <= merge(parport_primary_base_low, wdata, `WM_PP_BASE_LOW);
         if (hit(`IDX_BASE1_LOW, sel_pp))
            parport_secondary_base_low <= merge(parport_secondary_base_low, wdata, `WM_PP_BASE_LOW);
         // (RULE_12) fan/event low bits fixed
         if (hit(`IDX_BASE0_LOW, sel_fan))
            fan_base_low <= merge(fan_base_low, wdata, `WM_FAN_BASE_LOW);
         if (hit(`IDX_BASE1_LOW, sel_fan))
            power_event_base_low <= merge(power_event_base_low, wdata, `WM_FAN_BASE_LOW);
         // (RULE_16) interrupt level nibble
         if (hit(`IDX_IRQ_SELECT, sel_pp))
            parport_irq_select <= merge(parport_irq_select, wdata, `WM_IRQ);
         if (hit(`IDX_IRQ_SELECT, sel_fan))
            fan_irq_select <= merge(fan_irq_select, wdata, `WM_IRQ);
         // (RULE_17) DMA channel field
         if (hit(`IDX_DMA_SELECT, sel_pp))
            parport_dma_select <= merge(parport_dma_select, wdata, `WM_DMA);
         // (RULE_15) parallel special config
         if (hit(`IDX_CONFIG0, sel_pp))
            parport_mode_config <= merge(parport_mode_config, wdata, `WM_PP_MODE);
         // (RULE_19) wake enables writable; the flag assignment below overrides bit 7
         if (hit(`IDX_CONFIG0, sel_fan))
            power_event_enable_reg <= merge(power_event_enable_reg, wdata, `WM_PE_ENABLE);
         power_event_enable_reg[`PE_STANDBY_OFF_BIT] <= next_standby_flag;
      end
   end

   // decoded settings, registered so every output leaves a flip-flop
   always @(posedge clk_i) begin
      if (rst_i) begin
         // inactive single-bit settings, stopped card clock, no wake enables
         {s2_mode_sir_o, amplitude_shift_infrared_o, smart_card_mode_o, s2_irq_share_o, baud_div12_o,
            tx_turn_wait_o, rx_turn_wait_o, rx_mask_on_tx_o, sir_rx_active_low_o, parport_enable_o,
            card_power_switch_active_high_o, card_present_active_high_o, parport_irq_share_o,
            post_port_disable_o, fan_enable_o, standby_off_flag_o, card_detect_wake_enable_o,
            mouse_wake_enable_o, card_clock_select_o, other_wake_enable_o} <= 24'h000000;
         // standard mode, divide by 13, half duplex, both parallel modes on
         {s2_mode_standard_o, baud_div13_o, half_duplex_o, parport_ecp_enable_o, parport_epp_enable_o} <= 5'h1F;
         turn_wait_bits_o <= `IR_TURN_WAIT_BITS;
         card_clock_divisor_o <= 7'h7F;
         parport_primary_base_o <= 16'h0378;
         parport_secondary_base_o <= 16'h0778;
         parport_irq_o <= 4'h7;
         parport_dma_o <= 3'h3;
         fan_base_o <= 16'h0290;
         power_event_base_o <= 16'h0230;
         fan_irq_o <= 4'h9;
      end else begin
         // (RULE_01) one-hot mode decode, reserved codes select none
         s2_mode_standard_o <= (s2_mode == `S2_MODE_STANDARD);
         s2_mode_sir_o <= (s2_mode == `S2_MODE_SIR);
         amplitude_shift_infrared_o <= (s2_mode == `S2_MODE_ASK);
         smart_card_mode_o <= s2_card;
         s2_irq_share_o <= serial2_mode_config[0];
         // (RULE_02) baud source, reserved codes select none
         baud_div13_o <= (serial2_mode_config[2:1] == `BAUD_DIV13);
         baud_div12_o <= (serial2_mode_config[2:1] == `BAUD_DIV12);
         // (RULE_03) wait before transmit
         tx_turn_wait_o <= s2_infrared & ~serial2_infrared_config[7];
         // (RULE_04) wait before receive
         rx_turn_wait_o <= s2_infrared & ~serial2_infrared_config[6];
         turn_wait_bits_o <= `IR_TURN_WAIT_BITS;
         // (RULE_05) receive mask while transmitting
         rx_mask_on_tx_o <= serial2_infrared_config[5];
         // (RULE_06) duplex and polarity
         half_duplex_o <= serial2_infrared_config[4];
         sir_rx_active_low_o <= serial2_infrared_config[3];
         // (RULE_07) card settings held inactive outside card mode
         card_power_switch_active_high_o <= s2_card & serial2_card_clock_config[2];
         card_present_active_high_o <= s2_card & serial2_card_divisor_config[7];
         // (RULE_08) clock select, stopped outside card mode
         card_clock_select_o <= s2_card ? serial2_card_clock_config[1:0] : 2'h0;
         card_clock_divisor_o <= serial2_card_divisor_config[6:0];
         // (RULE_09) enables
         parport_enable_o <= parport_activate[0];
         fan_enable_o <= fan_activate[0];
         // (RULE_10) address bits 15:12 always zero
         parport_primary_base_o <= {parport_primary_base_high, parport_primary_base_low};
         parport_secondary_base_o <= {parport_secondary_base_high, parport_secondary_base_low};
         fan_base_o <= {fan_base_high, fan_base_low};
         power_event_base_o <= {power_event_base_high, power_event_base_low};
         parport_irq_o <= parport_irq_select[3:0];
         parport_dma_o <= parport_dma_select[2:0];
         fan_irq_o <= fan_irq_select[3:0];
         // (RULE_14) independent mode bits
         parport_ecp_enable_o <= parport_mode_config[1];
         // (RULE_13) base bit 2 blocks EPP
         parport_epp_enable_o <= parport_mode_config[0] & ~parport_primary_base_low[`PP_EPP_LOCK_BIT];
         // (RULE_15) share and POST port
         parport_irq_share_o <= parport_mode_config[2];
         post_port_disable_o <= parport_mode_config[3];
         standby_off_flag_o <= power_event_enable_reg[`PE_STANDBY_OFF_BIT];
         // (RULE_19) wake gates
         card_detect_wake_enable_o <= power_event_enable_reg[`PE_CARD_WAKE_BIT];
         mouse_wake_enable_o <= power_event_enable_reg[`PE_MOUSE_WAKE_BIT];
         other_wake_enable_o <= power_event_enable_reg[3:0];
      end
   end

endmodule // logical_device_config_bank

// ### dv/logical_device_config_bank_properties.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/10ps
module ldev_cfg_checker (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire [31:0] dat_o,
   input wire standby_supply_i,
   input wire standby_off_flag_o,
   input wire [15:0] parport_primary_base_o,
   input wire [15:0] fan_base_o,
   input wire parport_epp_enable_o,
   input wire s2_mode_standard_o,
   input wire s2_mode_sir_o,
   input wire amplitude_shift_infrared_o,
   input wire smart_card_mode_o,
   input wire tx_turn_wait_o,
   input wire [7:0] turn_wait_bits_o,
   input wire [1:0] card_clock_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request counts only on an edge with no answer pending
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   // one pulse, so a held strobe cannot be answered twice
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   chk_ack_pulse: assert property (s_take |=> s_answer)
      else $error("ack missing or wider than one cycle");
   chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   chk_standby_set: assert property (!standby_supply_i |-> ##2 standby_off_flag_o)
      else $error("standby flag not set after supply loss");
   chk_flag_cause: assert property ($rose(standby_off_flag_o) |-> !$past(standby_supply_i, 2))
      else $error("standby flag rose without supply loss");
   chk_epp_lock: assert property (parport_epp_enable_o |-> !parport_primary_base_o[2])
      else $error("epp enabled with base bit 2 set");
   chk_base_high_zero: assert property ((parport_primary_base_o[15:12] | fan_base_o[15:12]) == 4'h0)
      else $error("base address bits 15:12 not zero");
   chk_pp_low_zero: assert property (parport_primary_base_o[1:0] == 2'h0)
      else $error("parallel base bits 1:0 not zero");
   chk_fan_low_zero: assert property (fan_base_o[2:0] == 3'h0)
      else $error("fan base bits 2:0 not zero");
   chk_mode_onehot: assert property ($onehot0({s2_mode_standard_o, s2_mode_sir_o, amplitude_shift_infrared_o, smart_card_mode_o}))
      else $error("serial mode decode not one-hot");
   chk_turn_wait: assert property (tx_turn_wait_o |-> (s2_mode_sir_o || amplitude_shift_infrared_o) && turn_wait_bits_o == 8'h28)
      else $error("turnaround wait outside infrared modes");
   chk_card_gate: assert property (!smart_card_mode_o |-> card_clock_select_o == 2'h0)
      else $error("card clock running outside card mode");
endmodule // ldev_cfg_checker

bind logical_device_config_bank ldev_cfg_checker u_chk (.*);

// ### dv/test_logical_device_config_bank.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
`include "ldev_cfg_consts.vh"
module test_logical_device_config_bank;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, standby_supply_i = 1'b1;
   logic [9:0] adr_i = 10'h000;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   wire [31:0] dat_o;
   wire ack_o, s2_mode_standard_o, s2_mode_sir_o, amplitude_shift_infrared_o, smart_card_mode_o, s2_irq_share_o;
   wire baud_div13_o, baud_div12_o, tx_turn_wait_o, rx_turn_wait_o, rx_mask_on_tx_o, half_duplex_o;
   wire sir_rx_active_low_o, card_power_switch_active_high_o, card_present_active_high_o, parport_enable_o;
   wire parport_ecp_enable_o, parport_epp_enable_o, parport_irq_share_o, post_port_disable_o, fan_enable_o;
   wire standby_off_flag_o, card_detect_wake_enable_o, mouse_wake_enable_o;
   wire [7:0] turn_wait_bits_o;
   wire [1:0] card_clock_select_o;
   wire [6:0] card_clock_divisor_o;
   wire [15:0] parport_primary_base_o, parport_secondary_base_o, fan_base_o, power_event_base_o;
   wire [3:0] parport_irq_o, fan_irq_o, other_wake_enable_o;
   wire [2:0] parport_dma_o;
   integer miscompares = 0;
   integer check_count = 0;
   integer i;
   logic [7:0] rd_q; // byte taken at the ack edge
   // device, index, reset value, writable mask
   logic [27:0] tbl [0:18] = '{28'h3300001, 28'h4300001, 28'h360030F, 28'h460020F, 28'h36178FC,
      28'h46190F8, 28'h362070F, 28'h462020F, 28'h36378FC, 28'h46330F8, 28'h370070F, 28'h470090F,
      28'h3740307, 28'h2F00077, 28'h3F0030F, 28'h4F0005F, 28'h2F150F8, 28'h2F20007, 28'h2F37FFF};

   logical_device_config_bank dut (.*);

   // free-running 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   task check(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares = miscompares + 1;
         end
      end
   endtask

   // one classic cycle held until ack is sampled, then one idle cycle
   task wb(input [7:0] idx, input w, input [7:0] d);
      integer n;
      begin
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i <= w;
         adr_i <= {idx, 2'b00};
         dat_i <= {24'h0, d};
         n = 0;
         @(posedge clk_i);
         while (ack_o !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk_i);
         end
         if (n == 20) begin
            miscompares = miscompares + 1;
            summarize;
         end
         rd_q = dat_o[7:0];
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task rd(input [7:0] idx, input [7:0] exp);
      begin
         wb(idx, 1'b0, 8'h00);
         check({24'h0, rd_q}, {24'h0, exp});
      end
   endtask

   // defaults at reset, then every register but the device number written with all ones
   task t_table;
      begin
         check({parport_primary_base_o, parport_secondary_base_o}, 32'h03780778);
         check({fan_base_o, power_event_base_o}, 32'h02900230);
         check({parport_ecp_enable_o, parport_epp_enable_o, half_duplex_o, s2_mode_standard_o, baud_div13_o}, 5'h1F);
         for (i = 0; i < 19; i = i + 1) begin
            wb(`IDX_LDN, 1'b1, {4'h0, tbl[i][27:24]});
            rd(tbl[i][23:16], tbl[i][15:8]);
            wb(tbl[i][23:16], 1'b1, 8'hFF);
            rd(tbl[i][23:16], tbl[i][7:0]);
         end
         rd(8'h40, 8'h00);
         check({parport_primary_base_o, fan_base_o}, 32'h0FFC0FF8);
         check({parport_secondary_base_o, power_event_base_o}, 32'h0FFC0FF8);
         check({parport_irq_o, fan_irq_o, 1'b0, parport_dma_o}, 12'hFF7);
         check({parport_enable_o, fan_enable_o, parport_ecp_enable_o, parport_epp_enable_o}, 4'hE);
         check({post_port_disable_o, parport_irq_share_o}, 2'h3);
         check({card_detect_wake_enable_o, mouse_wake_enable_o, other_wake_enable_o}, 6'h3F);
         check(s2_irq_share_o, 1'b1);
         wb(`IDX_LDN, 1'b1, `LDN_FAN);
         wb(`IDX_ACTIVATE, 1'b1, 8'h00);
         wb(`IDX_LDN, 1'b1, `LDN_PARPORT);
         rd(`IDX_ACTIVATE, 8'h01);
         check({parport_enable_o, fan_enable_o}, 2'h2);
      end
   endtask

   // parallel mode codes, then the base bit that locks out epp
   task t_parmode;
      begin
         wb(`IDX_BASE0_LOW, 1'b1, 8'h78);
         for (i = 0; i < 4; i = i + 1) begin
            wb(`IDX_CONFIG0, 1'b1, i[7:0]);
            check({parport_ecp_enable_o, parport_epp_enable_o}, i[1:0]);
         end
         wb(`IDX_BASE0_LOW, 1'b1, 8'h7C);
         check({parport_ecp_enable_o, parport_epp_enable_o}, 2'h2);
      end
   endtask

   // every serial mode and clock code with waits enabled
   task t_serial;
      begin
         wb(`IDX_LDN, 1'b1, `LDN_SERIAL2);
         wb(`IDX_CONFIG1, 1'b1, 8'h08);
         wb(`IDX_CONFIG2, 1'b1, 8'h07);
         wb(`IDX_CONFIG3, 1'b1, 8'hAA);
         check({rx_mask_on_tx_o, half_duplex_o, sir_rx_active_low_o}, 3'h1);
         for (i = 0; i < 8; i = i + 1) begin
            wb(`IDX_CONFIG0, 1'b1, {1'b0, i[2:0], 1'b0, i[1:0], 1'b0});
            check({s2_mode_standard_o, s2_mode_sir_o, amplitude_shift_infrared_o, smart_card_mode_o},
               {i == 0, i == 1, i == 2, i == 4});
            check({baud_div13_o, baud_div12_o}, {i[1:0] == 2'h0, i[1:0] == 2'h1});
            check({tx_turn_wait_o, rx_turn_wait_o}, {2{i == 1 || i == 2}});
            check({card_clock_select_o, card_power_switch_active_high_o, card_present_active_high_o,
               card_clock_divisor_o}, {(i == 4) ? 4'hF : 4'h0, 7'h2A});
         end
         wb(`IDX_CONFIG0, 1'b1, 8'h10);
         wb(`IDX_CONFIG1, 1'b1, 8'hA8);
         check({tx_turn_wait_o, rx_turn_wait_o, turn_wait_bits_o}, 10'h128);
         check({rx_mask_on_tx_o, half_duplex_o, sir_rx_active_low_o}, 3'h5);
      end
   endtask

   // supply loss sets the flag; only a written one clears it
   task t_standby;
      begin
         wb(`IDX_LDN, 1'b1, `LDN_FAN);
         standby_supply_i <= 1'b0;
         @(posedge clk_i);
         standby_supply_i <= 1'b1;
         rd(`IDX_CONFIG0, 8'hDF);
         wb(`IDX_CONFIG0, 1'b1, 8'h00);
         rd(`IDX_CONFIG0, 8'h80);
         check(standby_off_flag_o, 1'b1);
         wb(`IDX_CONFIG0, 1'b1, 8'h80);
         rd(`IDX_CONFIG0, 8'h00);
         check(standby_off_flag_o, 1'b0);
      end
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_table;
      t_parmode;
      t_serial;
      t_standby;
      summarize;
   end
endmodule // test_logical_device_config_bank
